// >>> logic/memory_map_defines.vh
// Address map constants for the memory map decoder
// Behaviour
// - All addresses are 16-bit word addresses
// - Program 0x000000-0x007FFF selects program flash
// - Boot at word zero; watchdog reset at two
// - Program 0x008000-0x0087FF selects shared RAM
// - Data 0x000000-0x0007FF selects same dual-port RAM
// - Unlisted program and data ranges decode reserved
// - Data 0x00F000-0x00FFFF is peripheral window
// - Data 0xFFFF00-0xFFFFFF is debug register window
// - Debug upper addresses decode transmit, status, lock
// - Debug control, step counter, trace registers decode
// - Debug breakpoint and signal registers decode; rest reserved
// - First eight peripheral bases select their units
// - Remaining peripheral bases select their units
// - Vectors step by two; targets 19 bits
`ifndef MEMORY_MAP_DEFINES_VH
`define MEMORY_MAP_DEFINES_VH

// ==========================================================
// Widths
`define P_AW        21
`define D_AW        24
`define DW          16
`define RAM_AW      11
`define FLASH_AW    15
`define NPER        24
`define DBG_RW      5
`define VEC_TGT_W   19

// ==========================================================
// Program space
`define P_FLASH_LAST   21'h007fff
`define P_RAM_FIRST    21'h008000
`define P_RAM_LAST     21'h0087ff
`define P_BOOT_ADDR    21'h000000
`define P_WDOG_ADDR    21'h000002

// ==========================================================
// Data space
`define D_RAM_LAST     24'h0007ff
`define D_PER_FIRST    24'h00f000
`define D_PER_LAST     24'h00ffff
`define D_DBG_FIRST    24'hffff00

// ==========================================================
// Debug window low-byte offsets
`define DBG_TX_UPPER     8'hff
`define DBG_TXRX         8'hfe
`define DBG_TXRX_STAT    8'hfd
`define DBG_CORE_LOCK    8'hfc
`define DBG_CONTROL      8'ha0
`define DBG_STEP_HI      8'h9f
`define DBG_STEP         8'h9e
`define DBG_STATUS       8'h9d
`define DBG_PER_BASE     8'h9c
`define DBG_TRACE_CTRL   8'h9b
`define DBG_TRACE_PTR    8'h9a
`define DBG_TRACE_HI     8'h99
`define DBG_TRACE        8'h98
`define DBG_BKPT_CTRL_HI 8'h97
`define DBG_BKPT_CTRL    8'h96
`define DBG_BKPT_A1_HI   8'h95
`define DBG_BKPT_A1      8'h94
`define DBG_BKPT_A2_HI   8'h93
`define DBG_BKPT_A2      8'h92
`define DBG_BKPT_MSK_HI  8'h91
`define DBG_BKPT_MSK     8'h90
`define DBG_BKPT_CNT     8'h8e
`define DBG_EXT_SIG      8'h8a

// ==========================================================
// Debug register codes on the select index
`define DREG_NONE        5'h00
`define DREG_TX_UPPER    5'h01
`define DREG_TXRX        5'h02
`define DREG_TXRX_STAT   5'h03
`define DREG_CORE_LOCK   5'h04
`define DREG_CONTROL     5'h05
`define DREG_STEP        5'h06
`define DREG_STATUS      5'h07
`define DREG_PER_BASE    5'h08
`define DREG_TRACE_CTRL  5'h09
`define DREG_TRACE_PTR   5'h0a
`define DREG_TRACE       5'h0b
`define DREG_BKPT_CTRL   5'h0c
`define DREG_BKPT_A1     5'h0d
`define DREG_BKPT_A2     5'h0e
`define DREG_BKPT_MSK    5'h0f
`define DREG_BKPT_CNT    5'h10
`define DREG_EXT_SIG     5'h11

// ==========================================================
// Peripheral bases (low 12 bits of window), entry 0 last
// Order: timer, converter, pwm, intc, sys, wdog, clk, psup,
// gpio a-d, pit 0-2, dac 0-1, cmp a-b, serial, spi, i2c, flash, can
`define PER_BASES {12'h800, 12'h400, 12'h280, 12'h220, 12'h200, \
  12'h1f0, 12'h1e0, 12'h1d0, 12'h1c0, 12'h1b0, 12'h1a0, 12'h190, \
  12'h180, 12'h170, 12'h160, 12'h150, 12'h140, 12'h130, 12'h120, \
  12'h100, 12'h0e0, 12'h0c0, 12'h080, 12'h000}
// Span of each unit as an offset mask, same order
`define PER_SPANS {12'h03f, 12'h01f, 12'h01f, 12'h01f, 12'h01f, \
  12'h00f, 12'h00f, 12'h00f, 12'h00f, 12'h00f, 12'h00f, 12'h00f, \
  12'h00f, 12'h00f, 12'h00f, 12'h00f, 12'h00f, 12'h00f, 12'h00f, \
  12'h01f, 12'h01f, 12'h01f, 12'h03f, 12'h03f}

`endif

// >>> logic/periph_select.v
// Peripheral window base-address selector
`timescale 1ns/1ps
`default_nettype none
`include "memory_map_defines.vh"

module periph_select (
  // Window offset
  input  wire [11:0]        i_offset,
  input  wire               i_enable,
  // Selects
  output wire [`NPER-1:0]   o_sel,
  output wire [5:0]         o_reg_offset
);

  localparam [`NPER*12-1:0] BASES = `PER_BASES;
  localparam [`NPER*12-1:0] SPANS = `PER_SPANS;

  wire [`NPER*6-1:0] offs;

  // ========================================================
  // One comparator per unit; gaps match no entry
  genvar g;
  generate
    for (g = 0; g < `NPER; g = g + 1) begin : g_unit
      wire [11:0] span = SPANS[g*12 +: 12];
      assign o_sel[g] = i_enable &&
        ((i_offset & ~span) == BASES[g*12 +: 12]);
      assign offs[g*6 +: 6] = o_sel[g] ? (i_offset[5:0] & span[5:0]) : 6'h00;
    end
  endgenerate

  // At most one select is high, so OR-ing the offsets is a mux
  reg [5:0] off_or;
  integer k;
  always @* begin
    off_or = 6'h00;
    for (k = 0; k < `NPER; k = k + 1) begin
      off_or = off_or | offs[k*6 +: 6];
    end
  end
  assign o_reg_offset = off_or;

endmodule
`default_nettype wire

// >>> logic/memory_map_address_decoder.v
// Program and data space address decoder
`timescale 1ns/1ps
`default_nettype none
`include "memory_map_defines.vh"

module memory_map_address_decoder (
  // Clock and reset
  input  wire                  I_SYS_CLK,
  input  wire                  I_RESETN,
  // Reset cause
  input  wire                  i_WDOG_RESET,
  output reg  [`P_AW-1:0]      o_FETCH_START,
  // Vector fetch
  input  wire [13:0]           i_VECTOR_BASE,
  input  wire [6:0]            i_VEC_NUM,
  input  wire [`P_AW-1:0]      i_VEC_ENTRY,
  output reg  [`P_AW-1:0]      o_VEC_ADDR,
  output reg  [`P_AW-1:0]      o_VEC_TARGET,
  // Program bus
  input  wire                  i_P_REQ,
  input  wire [`P_AW-1:0]      i_P_ADDR,
  input  wire [`DW-1:0]        i_P_FLASH_RDATA,
  input  wire [`DW-1:0]        i_P_RAM_RDATA,
  output wire                  o_P_FLASH_SEL,
  output wire [`FLASH_AW-1:0]  o_P_FLASH_ADDR,
  output wire                  o_P_RAM_SEL,
  output wire [`RAM_AW-1:0]    o_P_RAM_ADDR,
  output reg  [`DW-1:0]        o_P_RDATA,
  output reg                   o_P_RVALID,
  output reg                   o_P_UNMAPPED,
  // Data bus
  input  wire                  i_D_REQ,
  input  wire                  i_D_WR,
  input  wire                  i_D_WORD,
  input  wire [`D_AW-1:0]      i_D_ADDR,
  input  wire [`DW-1:0]        i_D_RAM_RDATA,
  input  wire [`DW-1:0]        i_D_PER_RDATA,
  input  wire [`DW-1:0]        i_D_DBG_RDATA,
  output wire                  o_D_RAM_SEL,
  output wire [`RAM_AW-1:0]    o_D_RAM_ADDR,
  output wire [`NPER-1:0]      o_D_PER_SEL,
  output wire [5:0]            o_D_PER_OFFSET,
  output wire                  o_D_DBG_SEL,
  output reg  [`DBG_RW-1:0]    o_D_DBG_REG,
  output reg                   o_D_DBG_HI,
  output reg  [`DW-1:0]        o_D_RDATA,
  output reg                   o_D_RVALID,
  output reg                   o_D_UNMAPPED
);

  // ========================================================
  // Program space decode, word addresses throughout
  wire p_flash_hit = (i_P_ADDR <= `P_FLASH_LAST);
  wire p_ram_hit   = (i_P_ADDR >= `P_RAM_FIRST) &&
                     (i_P_ADDR <= `P_RAM_LAST);
  wire p_rsvd      = !p_flash_hit && !p_ram_hit;

  assign o_P_FLASH_SEL  = i_P_REQ && p_flash_hit;
  assign o_P_FLASH_ADDR = i_P_ADDR[`FLASH_AW-1:0];
  assign o_P_RAM_SEL    = i_P_REQ && p_ram_hit;
  // Same RAM cells the data side reaches from zero
  assign o_P_RAM_ADDR   = i_P_ADDR[`RAM_AW-1:0];

  // ========================================================
  // Data space decode
  wire d_ram_hit = (i_D_ADDR <= `D_RAM_LAST);
  wire d_per_win = (i_D_ADDR >= `D_PER_FIRST) &&
                   (i_D_ADDR <= `D_PER_LAST);
  wire d_dbg_win = (i_D_ADDR >= `D_DBG_FIRST);

  // Byte or long accesses to peripherals get no select
  wire per_en = i_D_REQ && d_per_win && i_D_WORD;

  periph_select u_periph_select (
    .i_offset     (i_D_ADDR[11:0]),
    .i_enable     (per_en),
    .o_sel        (o_D_PER_SEL),
    .o_reg_offset (o_D_PER_OFFSET)
  );

  wire d_per_hit = |o_D_PER_SEL;

  assign o_D_RAM_SEL  = i_D_REQ && d_ram_hit;
  assign o_D_RAM_ADDR = i_D_ADDR[`RAM_AW-1:0];

  // ========================================================
  // Debug window register index
  always @* begin
    o_D_DBG_HI = 1'b0;
    case (i_D_ADDR[7:0])
      `DBG_TX_UPPER:     o_D_DBG_REG = `DREG_TX_UPPER;
      `DBG_TXRX:         o_D_DBG_REG = `DREG_TXRX;
      `DBG_TXRX_STAT:    o_D_DBG_REG = `DREG_TXRX_STAT;
      `DBG_CORE_LOCK:    o_D_DBG_REG = `DREG_CORE_LOCK;
      `DBG_CONTROL:      o_D_DBG_REG = `DREG_CONTROL;
      `DBG_STEP_HI: begin
        o_D_DBG_REG = `DREG_STEP;
        o_D_DBG_HI  = 1'b1;
      end
      `DBG_STEP:         o_D_DBG_REG = `DREG_STEP;
      `DBG_STATUS:       o_D_DBG_REG = `DREG_STATUS;
      `DBG_PER_BASE:     o_D_DBG_REG = `DREG_PER_BASE;
      `DBG_TRACE_CTRL:   o_D_DBG_REG = `DREG_TRACE_CTRL;
      `DBG_TRACE_PTR:    o_D_DBG_REG = `DREG_TRACE_PTR;
      `DBG_TRACE_HI: begin
        o_D_DBG_REG = `DREG_TRACE;
        o_D_DBG_HI  = 1'b1;
      end
      `DBG_TRACE:        o_D_DBG_REG = `DREG_TRACE;
      `DBG_BKPT_CTRL_HI: begin
        o_D_DBG_REG = `DREG_BKPT_CTRL;
        o_D_DBG_HI  = 1'b1;
      end
      `DBG_BKPT_CTRL:    o_D_DBG_REG = `DREG_BKPT_CTRL;
      `DBG_BKPT_A1_HI: begin
        o_D_DBG_REG = `DREG_BKPT_A1;
        o_D_DBG_HI  = 1'b1;
      end
      `DBG_BKPT_A1:      o_D_DBG_REG = `DREG_BKPT_A1;
      `DBG_BKPT_A2_HI: begin
        o_D_DBG_REG = `DREG_BKPT_A2;
        o_D_DBG_HI  = 1'b1;
      end
      `DBG_BKPT_A2:      o_D_DBG_REG = `DREG_BKPT_A2;
      `DBG_BKPT_MSK_HI: begin
        o_D_DBG_REG = `DREG_BKPT_MSK;
        o_D_DBG_HI  = 1'b1;
      end
      `DBG_BKPT_MSK:     o_D_DBG_REG = `DREG_BKPT_MSK;
      `DBG_BKPT_CNT:     o_D_DBG_REG = `DREG_BKPT_CNT;
      `DBG_EXT_SIG:      o_D_DBG_REG = `DREG_EXT_SIG;
      default:           o_D_DBG_REG = `DREG_NONE;
    endcase
  end

  // Reserved debug locations select nothing
  wire d_dbg_hit = d_dbg_win && (o_D_DBG_REG != `DREG_NONE);
  assign o_D_DBG_SEL = i_D_REQ && d_dbg_hit;

  // Everything else in data space is reserved
  wire d_unmapped = !d_ram_hit && !d_per_hit && !d_dbg_hit;

  // ========================================================
  // Next read data, taken from the target selected this cycle
  // Unmapped reads give zero and writes there reach no target
  reg [`DW-1:0] p_rdata_nxt;
  reg [`DW-1:0] d_rdata_nxt;

  always @* begin
    p_rdata_nxt = 16'h0000;
    if (o_P_FLASH_SEL) begin
      p_rdata_nxt = i_P_FLASH_RDATA;
    end else if (o_P_RAM_SEL) begin
      p_rdata_nxt = i_P_RAM_RDATA;
    end
  end

  // A write returns zero so no stale word is mistaken for read data
  always @* begin
    d_rdata_nxt = 16'h0000;
    if (!i_D_WR) begin
      if (o_D_RAM_SEL) begin
        d_rdata_nxt = i_D_RAM_RDATA;
      end else if (d_per_hit) begin
        d_rdata_nxt = i_D_PER_RDATA;
      end else if (o_D_DBG_SEL) begin
        d_rdata_nxt = i_D_DBG_RDATA;
      end
    end
  end

  // ========================================================
  // Program read return, one cycle after the request
  always @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      o_P_RDATA    <= 16'h0000;
      o_P_RVALID   <= 1'b0;
      o_P_UNMAPPED <= 1'b0;
    end else begin
      o_P_RDATA    <= p_rdata_nxt;
      o_P_RVALID   <= i_P_REQ;
      o_P_UNMAPPED <= i_P_REQ && p_rsvd;
    end
  end

  // ========================================================
  // Data read return; nothing stalls, so every read request is answered
  always @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      o_D_RDATA    <= 16'h0000;
      o_D_RVALID   <= 1'b0;
      o_D_UNMAPPED <= 1'b0;
    end else begin
      o_D_RDATA    <= d_rdata_nxt;
      o_D_RVALID   <= i_D_REQ && !i_D_WR;
      o_D_UNMAPPED <= i_D_REQ && (d_unmapped || (d_per_win && !i_D_WORD));
    end
  end

  // ========================================================
  // Fetch start: cause is taken while reset is held
  always @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      o_FETCH_START <= i_WDOG_RESET ? `P_WDOG_ADDR : `P_BOOT_ADDR;
    end
  end

  // ========================================================
  // Vectors: two words per entry, 19-bit reachable target
  always @(posedge I_SYS_CLK) begin
    if (!I_RESETN) begin
      o_VEC_ADDR   <= 21'h000000;
      o_VEC_TARGET <= 21'h000000;
    end else begin
      o_VEC_ADDR   <= {i_VECTOR_BASE, 7'h00} + {13'h0000, i_VEC_NUM, 1'b0};
      o_VEC_TARGET <= {2'h0, i_VEC_ENTRY[`VEC_TGT_W-1:0]};
    end
  end

endmodule
`default_nettype wire

// >>> verification/mmd_chk_chk.sv
// Assertion checker for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
`include "memory_map_defines.vh"
module mmd_chk (
  // Watched ports
  input wire              I_SYS_CLK,
  input wire              I_RESETN,
  input wire              i_WDOG_RESET,
  input wire [20:0]       o_FETCH_START,
  input wire [13:0]       i_VECTOR_BASE,
  input wire [6:0]        i_VEC_NUM,
  input wire [20:0]       i_VEC_ENTRY,
  input wire [20:0]       o_VEC_ADDR,
  input wire [20:0]       o_VEC_TARGET,
  input wire              i_P_REQ,
  input wire [20:0]       i_P_ADDR,
  input wire              o_P_FLASH_SEL,
  input wire              o_P_RAM_SEL,
  input wire [15:0]       o_P_RDATA,
  input wire              o_P_RVALID,
  input wire              o_P_UNMAPPED,
  input wire              i_D_REQ,
  input wire              i_D_WORD,
  input wire [23:0]       i_D_ADDR,
  input wire              o_D_RAM_SEL,
  input wire [23:0]       o_D_PER_SEL,
  input wire              o_D_DBG_SEL,
  input wire [15:0]       o_D_RDATA,
  input wire              o_D_UNMAPPED
);
  default clocking cb @(posedge I_SYS_CLK); endclocking
  default disable iff (!I_RESETN);
  // ==========================================================
  // Program side
  sequence s_p_resv;
    i_P_REQ && i_P_ADDR >= 21'h008800;
  endsequence
  sequence s_p_zero;
    o_P_RVALID && o_P_UNMAPPED && o_P_RDATA == 16'h0;
  endsequence
  property p_p_resv;
    s_p_resv |=> s_p_zero;
  endproperty
  a_p_resv: assert property (p_p_resv) else $error("reserved fetch served");
  property p_p_flash;
    i_P_REQ && i_P_ADDR <= 21'h007fff
      |-> o_P_FLASH_SEL && !o_P_RAM_SEL ##1 o_P_RVALID && !o_P_UNMAPPED;
  endproperty
  a_p_flash: assert property (p_p_flash) else $error("flash fetch wrong");
  property p_p_ram;
    i_P_REQ && i_P_ADDR >= 21'h008000 && i_P_ADDR <= 21'h0087ff |-> o_P_RAM_SEL && !o_P_FLASH_SEL;
  endproperty
  a_p_ram: assert property (p_p_ram) else $error("program ram select wrong");
  property p_p_idle;
    !i_P_REQ |-> !o_P_FLASH_SEL && !o_P_RAM_SEL ##1 !o_P_RVALID;
  endproperty
  a_p_idle: assert property (p_p_idle) else $error("select without request");
  // ==========================================================
  // Data side
  property p_d_ram;
    i_D_REQ |-> o_D_RAM_SEL == (i_D_ADDR <= 24'h0007ff);
  endproperty
  a_d_ram: assert property (p_d_ram) else $error("data ram select wrong");
  property p_d_resv;
    i_D_REQ && (i_D_ADDR inside {[24'h000800:24'h00efff], [24'h010000:24'hfffeff]})
      |-> !o_D_RAM_SEL && o_D_PER_SEL == 24'h0 && !o_D_DBG_SEL
      ##1 o_D_UNMAPPED && o_D_RDATA == 16'h0;
  endproperty
  a_d_resv: assert property (p_d_resv) else $error("reserved data served");
  property p_d_per;
    o_D_PER_SEL != 24'h0 |-> $onehot(o_D_PER_SEL) && i_D_WORD && i_D_ADDR[23:12] == 12'h00f;
  endproperty
  a_d_per: assert property (p_d_per) else $error("peripheral select wrong");
  property p_d_dbg;
    o_D_DBG_SEL |-> i_D_ADDR[23:8] == 16'hffff;
  endproperty
  a_d_dbg: assert property (p_d_dbg) else $error("debug select outside window");
  // ==========================================================
  // Reset start address and vectors
  property p_fetch;
    $rose(I_RESETN) |-> o_FETCH_START == ($past(i_WDOG_RESET) ? 21'h000002 : 21'h000000);
  endproperty
  a_fetch: assert property (p_fetch) else $error("fetch start wrong");
  property p_fetch_hold;
    I_RESETN && $past(I_RESETN) |-> $stable(o_FETCH_START);
  endproperty
  a_fetch_hold: assert property (p_fetch_hold) else $error("fetch start moved");
  property p_vec;
    I_RESETN && $past(I_RESETN) |-> o_VEC_TARGET == ($past(i_VEC_ENTRY) & 21'h07ffff)
      && o_VEC_ADDR == {$past(i_VECTOR_BASE), 7'h0} + {$past(i_VEC_NUM), 1'b0};
  endproperty
  a_vec: assert property (p_vec) else $error("vector address wrong");
endmodule
bind memory_map_address_decoder mmd_chk u_mmd_chk (.*);
`default_nettype wire

// >>> verification/far_side_model.sv
// Target memories and units answering the decoder's selects
`timescale 1ns/1ps
`default_nettype none
module far_side_model (
  // Selects
  input wire              i_clk,
  input wire              i_fl_sel,
  input wire [14:0]       i_fl_addr,
  input wire              i_pr_sel,
  input wire [10:0]       i_pr_addr,
  input wire              i_dr_sel,
  input wire [10:0]       i_dr_addr,
  input wire [23:0]       i_per_sel,
  input wire [5:0]        i_per_off,
  input wire              i_dbg_sel,
  input wire              i_dbg_hi,
  input wire [4:0]        i_dbg_reg,
  // Read data
  output wire [15:0]      o_fl_rd,
  output wire [15:0]      o_pr_rd,
  output wire [15:0]      o_dr_rd,
  output wire [15:0]      o_pe_rd,
  output wire [15:0]      o_db_rd
);
  // Unselected targets show churn so a missed select never reads as a match
  logic [15:0]            noise_r = 16'h1;
  always @(posedge i_clk) begin
    noise_r <= noise_r * 16'h0005 + 16'h3c1d;
  end
  assign o_fl_rd = i_fl_sel ? {1'b1, i_fl_addr} : noise_r;
  assign o_pr_rd = i_pr_sel ? {5'h0a, i_pr_addr} : ~noise_r;
  assign o_dr_rd = i_dr_sel ? {5'h0a, i_dr_addr} : noise_r;
  assign o_pe_rd = |i_per_sel ? i_per_sel[15:0] ^ {i_per_sel[23:16], 2'b0, i_per_off} : ~noise_r;
  assign o_db_rd = i_dbg_sel ? {10'h3a5, i_dbg_hi, i_dbg_reg} : noise_r;
endmodule
`default_nettype wire

// >>> verification/tb_memory_map_address_decoder.sv
// Self-checking bench for the memory map decoder
`timescale 1ns/1ps
`default_nettype none
module tb_memory_map_address_decoder;
  // ==========================================================
  // Signals
  logic        clk = 1'b0, rstn = 1'b0, wdog = 1'b0, p_req = 1'b0, d_req = 1'b0;
  logic        d_wr = 1'b0, d_word = 1'b1;
  logic [13:0] vbase = 14'h0;
  logic [6:0]  vnum = 7'h0;
  logic [20:0] ventry = 21'h0, p_addr = 21'h0, fetch, vaddr, vtgt, e_va, e_vt;
  logic [23:0] d_addr = 24'h0, per_sel;
  logic [15:0] fl_rd, pr_rd, dr_rd, pe_rd, db_rd, p_rdata, d_rdata, e_prd, e_drd;
  logic [14:0] fl_addr;
  logic [10:0] pr_addr, dr_addr;
  logic [5:0]  per_off;
  logic [4:0]  dbg_reg;
  logic        fl_sel, pr_sel, p_rv, p_um, dr_sel, dbg_sel, dbg_hi, d_rv, d_um;
  logic        e_prv, e_pum, e_drv, e_dum;
  int          n_fail = 0, checks = 0, cyc = 0;
  int pb[24] = '{'h000, 'h080, 'h0c0, 'h0e0, 'h100, 'h120, 'h130, 'h140, 'h150, 'h160, 'h170,
    'h180, 'h190, 'h1a0, 'h1b0, 'h1c0, 'h1d0, 'h1e0, 'h1f0, 'h200, 'h220, 'h280, 'h400, 'h800};
  int ps[24] = '{'h40, 'h40, 'h20, 'h20, 'h20, 'h10, 'h10, 'h10, 'h10, 'h10, 'h10, 'h10, 'h10,
    'h10, 'h10, 'h10, 'h10, 'h10, 'h10, 'h20, 'h20, 'h20, 'h20, 'h40};
  logic [23:0] bl[12] = '{24'h0, 24'h2, 24'h7ff, 24'h800, 24'h7fff, 24'h8000, 24'h87ff,
    24'h8800, 24'hefff, 24'h10000, 24'hfffeff, 24'h1fffff};
  memory_map_address_decoder u_memory_map_address_decoder (.I_SYS_CLK(clk), .I_RESETN(rstn),
    .i_WDOG_RESET(wdog), .o_FETCH_START(fetch), .i_VECTOR_BASE(vbase), .i_VEC_NUM(vnum),
    .i_VEC_ENTRY(ventry), .o_VEC_ADDR(vaddr), .o_VEC_TARGET(vtgt), .i_P_REQ(p_req),
    .i_P_ADDR(p_addr), .i_P_FLASH_RDATA(fl_rd), .i_P_RAM_RDATA(pr_rd), .o_P_FLASH_SEL(fl_sel),
    .o_P_FLASH_ADDR(fl_addr), .o_P_RAM_SEL(pr_sel), .o_P_RAM_ADDR(pr_addr), .o_P_RDATA(p_rdata),
    .o_P_RVALID(p_rv), .o_P_UNMAPPED(p_um), .i_D_REQ(d_req), .i_D_WR(d_wr), .i_D_WORD(d_word),
    .i_D_ADDR(d_addr), .i_D_RAM_RDATA(dr_rd), .i_D_PER_RDATA(pe_rd), .i_D_DBG_RDATA(db_rd),
    .o_D_RAM_SEL(dr_sel), .o_D_RAM_ADDR(dr_addr), .o_D_PER_SEL(per_sel), .o_D_PER_OFFSET(per_off),
    .o_D_DBG_SEL(dbg_sel), .o_D_DBG_REG(dbg_reg), .o_D_DBG_HI(dbg_hi), .o_D_RDATA(d_rdata),
    .o_D_RVALID(d_rv), .o_D_UNMAPPED(d_um));
  far_side_model u_far_side_model (.i_clk(clk), .i_fl_sel(fl_sel), .i_fl_addr(fl_addr),
    .i_pr_sel(pr_sel), .i_pr_addr(pr_addr), .i_dr_sel(dr_sel), .i_dr_addr(dr_addr),
    .i_per_sel(per_sel), .i_per_off(per_off), .i_dbg_sel(dbg_sel), .i_dbg_hi(dbg_hi),
    .i_dbg_reg(dbg_reg), .o_fl_rd(fl_rd), .o_pr_rd(pr_rd), .o_dr_rd(dr_rd), .o_pe_rd(pe_rd),
    .o_db_rd(db_rd));
  always #2 clk = ~clk;
  // ==========================================================
  // Helpers
  task stop_test();
    if (n_fail == 0 && checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      stop_test();
    end
  end
  task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s exp %h got %h", nm, e, g);
    end
  endtask
  // Debug code in [4:0], upper-word flag in [5]
  function automatic logic [5:0] dbg_exp(input logic [7:0] b);
    dbg_exp = 6'h0;
    if (b >= 8'hfc) dbg_exp = {1'b0, 5'(8'h0 - b)};
    if (b == 8'ha0) dbg_exp = 6'h05;
    if (b == 8'h8e) dbg_exp = 6'h10;
    if (b == 8'h8a) dbg_exp = 6'h11;
    if (b[7:4] == 4'h9) dbg_exp = b[3:0] >= 4'he ? {b[0], 5'h06} :
      b[3:0] >= 4'ha ? {1'b0, 5'h14 - 5'(b[3:0])} : {b[0], 5'h0f - 5'(b[3:1])};
  endfunction
  task do_reset(input logic w);
    @(posedge clk);
    #1;
    rstn = 1'b0;
    wdog = w;
    p_req = 1'b0;
    d_req = 1'b0;
    repeat (8) @(posedge clk);
    #1;
    rstn = 1'b1;
    {e_prv, e_pum, e_drv, e_dum} = 4'h0;
    e_va = {vbase, 7'h0} + {13'h0, vnum, 1'b0};
    e_vt = {2'b0, ventry[18:0]};
    chk("fetch_start", w ? 21'h2 : 21'h0, fetch);
  endtask
  task acc(input logic pq, input logic [20:0] pa, input logic dq, dw, dwd, input logic [23:0] da);
    logic [23:0] es;
    logic [5:0] eo, dx;
    logic er, ed;
    @(posedge clk);
    #1;
    chk("p_rvalid", e_prv, p_rv);
    chk("p_unmapped", e_pum, p_um);
    if (e_prv) chk("p_rdata", e_prd, p_rdata);
    chk("d_rvalid", e_drv, d_rv);
    chk("d_unmapped", e_dum, d_um);
    if (e_drv) chk("d_rdata", e_drd, d_rdata);
    chk("vec_addr", e_va, vaddr);
    chk("vec_target", e_vt, vtgt);
    {p_req, p_addr, d_req, d_wr, d_word, d_addr} = {pq, pa, dq, dw, dwd, da};
    {vbase, vnum, ventry} = 42'({$urandom, $urandom});
    es = 24'h0;
    eo = 6'h0;
    for (int i = 0; i < 24; i++) begin
      if (dwd && da[23:12] == 12'h00f && da[11:0] >= pb[i] && da[11:0] < pb[i] + ps[i]) begin
        es[i] = 1'b1;
        eo = 6'(da[11:0] - pb[i]);
      end
    end
    dx = dbg_exp(da[7:0]);
    er = da <= 24'h0007ff;
    ed = da[23:8] == 16'hffff && dx[4:0] != 5'h0;
    #1;
    chk("p_flash_sel", pq && pa <= 21'h007fff, fl_sel);
    chk("p_ram_sel", pq && pa inside {[21'h008000:21'h0087ff]}, pr_sel);
    chk("p_flash_addr", pa[14:0], fl_addr);
    chk("p_ram_addr", pa[10:0], pr_addr);
    chk("d_ram_addr", da[10:0], dr_addr);
    chk("d_dbg_reg", dx[4:0], dbg_reg);
    chk("d_ram_sel", dq && er, dr_sel);
    chk("d_per_sel", dq ? es : 24'h0, per_sel);
    chk("d_per_offset", dq ? eo : 6'h0, per_off);
    chk("d_dbg_sel", dq && ed, dbg_sel);
    if (ed) chk("d_dbg_hi", dx[5], dbg_hi);
    e_prv = pq;
    e_pum = pq && pa >= 21'h008800;
    e_prd = !pq ? 16'h0 : pa <= 21'h007fff ? {1'b1, pa[14:0]} :
      pa <= 21'h0087ff ? {5'h0a, pa[10:0]} : 16'h0;
    e_drv = dq && !dw;
    e_dum = dq && !(er || es != 24'h0 || ed);
    e_drd = er ? {5'h0a, da[10:0]} : es != 24'h0 ? es[15:0] ^ {es[23:16], 2'b0, eo} :
      ed ? {10'h3a5, dx[5], dx[4:0]} : 16'h0;
    e_va = {vbase, 7'h0} + {13'h0, vnum, 1'b0};
    e_vt = {2'b0, ventry[18:0]};
  endtask
  // ==========================================================
  // Scenarios
  initial begin
    void'($urandom(32'h1dd5));
    do_reset(1'b0);
    foreach (bl[i]) acc(1'b1, bl[i][20:0], 1'b1, 1'b0, 1'b1, bl[i]);
    acc(1'b1, 21'h008005, 1'b1, 1'b0, 1'b1, 24'h000005);
    for (int i = 0; i < 24; i++) begin
      acc(1'b0, 21'h0, 1'b1, 1'b0, 1'b1, 24'(32'h00f000 + pb[i]));
      acc(1'b0, 21'h0, 1'b1, 1'b0, 1'b1, 24'(32'h00f000 + pb[i] + ps[i] - 1));
      acc(1'b0, 21'h0, 1'b1, 1'b0, 1'b1, 24'(32'h00f000 + pb[i] + ps[i]));
      acc(1'b0, 21'h0, 1'b1, 1'b0, 1'b0, 24'(32'h00f000 + pb[i]));
      acc(1'b0, 21'h0, 1'b1, 1'b1, 1'b1, 24'(32'h00f000 + pb[i]));
    end
    for (int b = 0; b < 256; b++) acc(1'b0, 21'h0, 1'b1, b[0], 1'b1, {16'hffff, 8'(b)});
    repeat (300) acc(1'($urandom), 21'($urandom), 1'b1, 1'($urandom), 1'($urandom),
      $urandom % 2 ? {12'h00f, 12'($urandom)} : 24'($urandom));
    acc(1'b0, 21'h0, 1'b0, 1'b0, 1'b1, 24'h00f000);
    do_reset(1'b1);
    repeat (3) acc(1'b0, 21'h0, 1'b0, 1'b0, 1'b1, 24'hfffffe);
    chk("fetch_hold", 21'h2, fetch);
    do_reset(1'b0);
    stop_test();
  end
endmodule
`default_nettype wire
